// ==== core/hbc_host_port.sv ====
/*
  Host bus command port of the disk/tape controller: command byte
  capture on strobe 1, address match, parity check, command decode,
  interrupt mask, select latch, status latch and data bus driver.
  Assumes host pins are asynchronous to i_clk and held stable around
  the strobe; controller-core signals share i_clk.
*/
`timescale 1ns/1ps
// Contract
// - Device address comes from four jumpers in binary, factory value eight.
// - Command byte holds code in bits 7..4, address in bits 3..0.
// - Commands latch on strobe 1 only; strobe 2 is ignored.
// - Code 0111 enters read data mode toward the host.
// - Code 0110 clears the interrupt mask.
// - Code 0101 sets the interrupt mask.
// - Parity error and invalid request interrupts pass even when masked.
// - Mask is set after power-up and after software reset.
// - Code 0100 sets select latch; controller clears it when ready.
// - Code 0011 returns a fixed identification byte on the data lines.
// - Code 0010 enters write data mode from the host.
// - Code 0001 drives the status latch onto the data lines.
// - Code 0000 performs a software reset to the initialized state.
// - Software reset starts no diagnostics and leaves drives untouched.
// - Status latch is eight bits, returned only for the status read.
// - Status bit 7 gives direction, valid while request is one.
// - Status bit 6 is busy; no interruption accepted while set.
// - Status bit 5 is command or data, valid while request is one.
// - Loopback jumper loops diagnostics, flashes light at 1 Hz, off on failure.
// - Status bit 3 is the request flag validating bits 7, 5, 4.
// - Status bit 2 set on data read or write while request is zero.
// - Parity error ignores the command, sets status bit 1, interrupts.
// - Status bit 0 is one while diagnostics run or failed; a diagnostic pass clears it even while loopback keeps them running.
module hbc_host_port import hbc_pkg::*; #(
  parameter int LED_HALF = LED_HALF_CYCLES
) (
  input wire logic i_clk,               // Controller clock, 50 MHz
  input wire logic i_reset,             // Synchronous reset, high
  input wire logic [3:0] i_addr_jumper, // Address jumpers, binary
  input wire logic i_loopback_jumper,   // Diagnostic loopback jumper
  input wire logic i_parity_off_jumper, // High disables parity check
  input wire logic [7:0] i_cmd_addr,    // Host command/address byte
  input wire logic i_cmd_parity,        // Host command parity bit
  input wire logic i_strobe1,           // Host command strobe 1
  input wire logic i_strobe2,           // Host strobe 2, unused
  input wire logic [7:0] i_data,        // Host data lines, input side
  input wire logic [7:0] i_ctl_rd_byte, // Core byte for host reads
  input wire logic i_ctl_dir,           // Core: controller to host
  input wire logic i_ctl_busy,          // Core: active after select
  input wire logic i_ctl_cmd_data,      // Core: command/status phase
  input wire logic i_ctl_message,       // Core: message pending
  input wire logic i_ctl_request,       // Core: byte to transfer
  input wire logic i_ctl_ready,         // Core: ready for a command
  input wire logic i_ctl_irq,           // Core: maskable interrupt
  input wire logic i_diag_pass,         // Diagnostics passed, pulse
  input wire logic i_diag_fail,         // Diagnostics failed, pulse
  output logic [7:0] o_data,            // Host data lines, output side
  output logic o_data_oe,               // Host data lines enable
  output logic [7:0] o_wr_byte,         // Filtered host data to core
  output logic o_read_mode,             // Read data mode active
  output logic o_write_mode,            // Write data mode active
  output logic o_select,                // Select latch
  output logic o_int_mask,              // Interrupt mask, high masks
  output logic o_irq,                   // Interrupt request to host
  output logic o_soft_reset,            // Software reset pulse
  output logic o_diag_run,              // Diagnostics should run
  output logic o_power_led              // Power status light
);

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] pin;
  logic [7:0] cmd_byte;
  logic cmd_par;
  logic strobe_lvl;
  logic strobe_prev;
  logic strobe_rise;
  logic [3:0] dev_addr;
  logic par_bad;
  logic addr_hit;
  logic [3:0] cmd_code;
  logic take;
  logic soft_rst;
  hbc_mode_t mode;
  hbc_mode_t next_mode;
  logic invalid_request_flag_flag;
  logic parerr_flag;
  logic por_flag;
  logic diag_failed;
  logic [7:0] status_latch;

  function automatic logic parity_ok(input logic [7:0] b, input logic p);
    parity_ok = ((^b) ^ p) == PARITY_SENSE;
  endfunction

  // Strobe 2 is deliberately left out of the pin bundle
  assign pin_raw = {i_parity_off_jumper, i_loopback_jumper, i_addr_jumper,
                    i_data, i_strobe1, i_cmd_parity, i_cmd_addr};

  // Three-stage synchroniser; stage one feeds stage two only
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A bit changes once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin <= '0;
    end else begin
      pin <= (sync2 & sync3) | (pin & (sync2 ^ sync3));
    end
  end

  assign cmd_byte = pin[7:0];
  assign cmd_par = pin[8];
  assign strobe_lvl = pin[9];

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      strobe_prev <= 1'b0;
    end else begin
      strobe_prev <= strobe_lvl;
    end
  end

  assign strobe_rise = strobe_lvl && !strobe_prev;

  // Address follows jumpers once they settle, factory value at reset
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      dev_addr <= FACTORY_ADDR;
    end else begin
      dev_addr <= pin[21:18];
    end
  end

  assign cmd_code = cmd_byte[CMD_CODE_MSB:CMD_CODE_LSB];
  assign addr_hit = cmd_byte[CMD_ADDR_MSB:CMD_ADDR_LSB] == dev_addr;
  assign par_bad = strobe_rise && !pin[23] && !parity_ok(cmd_byte, cmd_par);
  assign take = strobe_rise && !par_bad && addr_hit;
  assign soft_rst = take && cmd_code == CMD_SW_RESET;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_soft_reset <= 1'b0;
    end else begin
      o_soft_reset <= soft_rst;
    end
  end

  // Port mode selected by the last accepted command
  always_comb begin
    next_mode = mode;
    if (take) begin
      unique case (cmd_code)
        CMD_READ_DATA: next_mode = HBC_RD_DATA;
        CMD_WRITE_DATA: next_mode = HBC_WR_DATA;
        CMD_IDENT_READ: next_mode = HBC_IDENT;
        CMD_STATUS_READ: next_mode = HBC_STATUS;
        default: next_mode = HBC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mode <= HBC_IDLE;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_read_mode <= 1'b0;
      o_write_mode <= 1'b0;
    end else begin
      o_read_mode <= next_mode == HBC_RD_DATA;
      o_write_mode <= next_mode == HBC_WR_DATA;
    end
  end

  // Interrupt mask: masked at reset and on software reset
  always_ff @(posedge i_clk) begin
    if (i_reset || soft_rst) begin
      o_int_mask <= MASK_RESET;
    end else if (take && cmd_code == CMD_DISABLE_INT) begin
      o_int_mask <= 1'b1;
    end else if (take && cmd_code == CMD_ENABLE_INT) begin
      o_int_mask <= 1'b0;
    end
  end

  // Select latch; a new select wins over the core's clear
  always_ff @(posedge i_clk) begin
    if (i_reset || soft_rst) begin
      o_select <= 1'b0;
    end else if (take && cmd_code == CMD_SELECT && !i_ctl_busy) begin
      o_select <= 1'b1;
    end else if (i_ctl_ready) begin
      o_select <= 1'b0;
    end
  end

  // Invalid request: data command with no byte pending
  always_ff @(posedge i_clk) begin
    if (i_reset || soft_rst) begin
      invalid_request_flag_flag <= 1'b0;
    end else if (take && !i_ctl_request &&
                 (cmd_code == CMD_READ_DATA || cmd_code == CMD_WRITE_DATA)) begin
      invalid_request_flag_flag <= 1'b1;
    end else if (take && cmd_code == CMD_STATUS_READ) begin
      invalid_request_flag_flag <= 1'b0;
    end
  end

  // Parity error from any address; set wins over the read clear
  always_ff @(posedge i_clk) begin
    if (i_reset || soft_rst) begin
      parerr_flag <= 1'b0;
    end else if (par_bad) begin
      parerr_flag <= 1'b1;
    end else if (take && cmd_code == CMD_STATUS_READ) begin
      parerr_flag <= 1'b0;
    end
  end

  // Diagnostics state survives software reset
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      por_flag <= POR_RESET;
    end else if (i_diag_fail) begin
      por_flag <= 1'b1;
    end else if (i_diag_pass && !diag_failed) begin
      por_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      diag_failed <= 1'b0;
    end else if (i_diag_fail) begin
      diag_failed <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_diag_run <= 1'b1;
    end else begin
      o_diag_run <= !diag_failed && (pin[22] || por_flag);
    end
  end

  // Qualified bits read zero while no byte is requested
  always_comb begin
    status_latch = 8'h00;
    status_latch[ST_DIR] = i_ctl_request && i_ctl_dir;
    status_latch[ST_BUSY] = i_ctl_busy;
    status_latch[ST_CMD_DATA] = i_ctl_request && i_ctl_cmd_data;
    status_latch[ST_MSG] = i_ctl_request && i_ctl_message;
    status_latch[ST_REQ] = i_ctl_request;
    status_latch[ST_INVALID_REQUEST_FLAG] = invalid_request_flag_flag;
    status_latch[ST_PARERR] = parerr_flag;
    status_latch[ST_POR] = por_flag;
  end

  // Error interrupts bypass the mask; busy holds off core interrupts
  always_ff @(posedge i_clk) begin
    if (i_reset || soft_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= parerr_flag || invalid_request_flag_flag ||
               (i_ctl_irq && !o_int_mask && !i_ctl_busy);
    end
  end

  // Data line driver by mode; status only after a status read
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      unique case (next_mode)
        HBC_RD_DATA: begin
          o_data <= i_ctl_rd_byte;
          o_data_oe <= 1'b1;
        end
        HBC_IDENT: begin
          o_data <= IDENT_BYTE;
          o_data_oe <= 1'b1;
        end
        HBC_STATUS: begin
          o_data <= status_latch;
          o_data_oe <= 1'b1;
        end
        default: begin
          o_data <= 8'h00;
          o_data_oe <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_wr_byte <= 8'h00;
    end else begin
      o_wr_byte <= pin[17:10];
    end
  end

  hbc_led_flasher #(
    .HALF_CYCLES(LED_HALF)
  ) u_led (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_loopback(pin[22]),
    .i_failed(diag_failed),
    .o_led(o_power_led)
  );

endmodule

// ==== core/hbc_led_flasher.sv ====
/*
  Power status light driver. Steady on normally, flashes at the
  loopback rate while diagnostics loop, held off after a failure.
  Assumes the single controller clock and a synchronous reset.
*/
`timescale 1ns/1ps
module hbc_led_flasher import hbc_pkg::*; #(
  parameter int HALF_CYCLES = LED_HALF_CYCLES
) (
  input wire logic i_clk,      // Controller clock
  input wire logic i_reset,    // Synchronous reset, high
  input wire logic i_loopback, // Diagnostics looping
  input wire logic i_failed,   // Diagnostic failure seen
  output logic o_led           // Power light, high lit
);

  logic [31:0] div_count;
  logic tick;
  logic phase;

  // Divider gives one enable pulse each half period
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_loopback || div_count == 32'(HALF_CYCLES - 1)) begin
      div_count <= 32'h0;
    end else begin
      div_count <= div_count + 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tick <= 1'b0;
    end else begin
      tick <= i_loopback && div_count == 32'(HALF_CYCLES - 1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || !i_loopback) begin
      phase <= 1'b1;
    end else if (tick) begin
      phase <= ~phase;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_led <= 1'b1;
    end else if (i_failed) begin
      o_led <= 1'b0;
    end else begin
      o_led <= phase;
    end
  end

endmodule

// ==== core/hbc_pkg.sv ====
/*
  Shared constants of the host bus command port: command codes, command
  byte layout, status latch bit positions, reset values and timing.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package hbc_pkg;

  // Command byte layout
  localparam int CMD_CODE_MSB = 7;
  localparam int CMD_CODE_LSB = 4;
  localparam int CMD_ADDR_MSB = 3;
  localparam int CMD_ADDR_LSB = 0;

  // Command codes, high nibble of the command byte
  localparam logic [3:0] CMD_READ_DATA = 4'h7;
  localparam logic [3:0] CMD_ENABLE_INT = 4'h6;
  localparam logic [3:0] CMD_DISABLE_INT = 4'h5;
  localparam logic [3:0] CMD_SELECT = 4'h4;
  localparam logic [3:0] CMD_IDENT_READ = 4'h3;
  localparam logic [3:0] CMD_WRITE_DATA = 4'h2;
  localparam logic [3:0] CMD_STATUS_READ = 4'h1;
  localparam logic [3:0] CMD_SW_RESET = 4'h0;

  // Factory jumper address
  localparam logic [3:0] FACTORY_ADDR = 4'h8;

  // Identification byte, value arbitrary
  localparam logic [7:0] IDENT_BYTE = 8'h5A;

  // Command parity sense: odd over byte plus parity bit
  localparam logic PARITY_SENSE = 1'b1;

  // Interface status latch bit positions
  localparam int ST_DIR = 7;
  localparam int ST_BUSY = 6;
  localparam int ST_CMD_DATA = 5;
  localparam int ST_MSG = 4;
  localparam int ST_REQ = 3;
  localparam int ST_INVALID_REQUEST_FLAG = 2;
  localparam int ST_PARERR = 1;
  localparam int ST_POR = 0;

  // Reset values
  localparam logic MASK_RESET = 1'b1;
  localparam logic POR_RESET = 1'b1;

  // Timing
  localparam longint CLK_HZ = 50000000;
  localparam longint LED_FLASH_HZ = 1;
  localparam int LED_HALF_CYCLES = int'(CLK_HZ / (2 * LED_FLASH_HZ));

  // Width of the synchronised pin bundle
  localparam int PIN_W = 24;

  typedef enum logic [4:0] {
    HBC_IDLE = 5'b00001,
    HBC_RD_DATA = 5'b00010,
    HBC_WR_DATA = 5'b00100,
    HBC_IDENT = 5'b01000,
    HBC_STATUS = 5'b10000
  } hbc_mode_t;

endpackage

// ==== test/hbc_host_model.sv ====
/*
  Host processor model: sends command bytes with parity and a strobe.
  Assumes the controller clock; inverts the idle command bus afterwards.
*/
`timescale 1ns/1ps
module hbc_host_model import hbc_pkg::*; (
  input wire logic i_clk,         // Controller clock
  output logic [7:0] o_cmd_addr,  // Command byte
  output logic o_cmd_parity,      // Parity bit
  output logic o_strobe1,         // Command strobe
  output logic o_strobe2          // Second strobe
);
  initial begin
    o_cmd_addr = 8'h00;
    o_cmd_parity = 1'b1;
    o_strobe1 = 1'b0;
    o_strobe2 = 1'b0;
  end
  task automatic send(input logic [3:0] code, input logic [3:0] addr, input logic bad, input logic use2);
    logic [7:0] b;
    b = {code, addr};
    @(posedge i_clk);
    o_cmd_addr <= b;
    o_cmd_parity <= (~^b) ^ bad;
    repeat (6) @(posedge i_clk);
    if (use2) o_strobe2 <= 1'b1;
    else o_strobe1 <= 1'b1;
    repeat (8) @(posedge i_clk);
    o_strobe1 <= 1'b0;
    o_strobe2 <= 1'b0;
    repeat (2) @(posedge i_clk);
    o_cmd_addr <= ~b;
    o_cmd_parity <= (~^b) ^ bad ^ 1'b1;
    repeat (4) @(posedge i_clk);
    if (code == CMD_SW_RESET) repeat (1000) @(posedge i_clk);
  endtask
endmodule

// ==== test/hbc_host_port_assertions.sv ====
/*
  Pin-level assertions for the host command port.
  Bound to every hbc_host_port; sees only its ports, one clock domain.
*/
`timescale 1ns/1ps
module hbc_host_port_assertions import hbc_pkg::*; #(
  parameter int LED_HALF = LED_HALF_CYCLES
) (
  input wire logic i_clk,             // Controller clock
  input wire logic i_reset,           // Synchronous reset
  input wire logic i_loopback_jumper, // Loopback jumper
  input wire logic [7:0] i_ctl_rd_byte, // Core read byte
  input wire logic i_ctl_busy,        // Core busy
  input wire logic i_ctl_ready,       // Core ready
  input wire logic i_ctl_irq,         // Core interrupt
  input wire logic i_diag_fail,       // Diagnostic failure
  input wire logic [7:0] o_data,      // Data lines out
  input wire logic o_data_oe,         // Data enable
  input wire logic o_read_mode,       // Read mode
  input wire logic o_write_mode,      // Write mode
  input wire logic o_select,          // Select latch
  input wire logic o_int_mask,        // Interrupt mask
  input wire logic o_irq,             // Interrupt request
  input wire logic o_soft_reset,      // Software reset pulse
  input wire logic o_diag_run,        // Diagnostics run
  input wire logic o_power_led        // Power light
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  int led_cnt;
  logic armed;
  always_ff @(posedge i_clk) begin
    if (i_reset) led_cnt <= 0;
    else if ($changed(o_power_led)) led_cnt <= 1;
    else led_cnt <= led_cnt + 1;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) armed <= 1'b0;
    else if ($changed(o_power_led) && i_loopback_jumper) armed <= 1'b1;
  end
  sequence s_cleared;
    o_int_mask && !o_select && !o_read_mode && !o_write_mode;
  endsequence
  sequence s_one_shot;
    s_cleared ##1 !o_soft_reset;
  endsequence
  a_mask_at_reset: assert property ($fell(i_reset) |-> o_int_mask && !o_select && o_diag_run)
    else $error("mask or select wrong after reset");
  a_irq_unmasked: assert property (!o_int_mask && i_ctl_irq && !i_ctl_busy |=> o_irq)
    else $error("unmasked core interrupt not raised");
  a_modes_exclusive: assert property (!(o_read_mode && o_write_mode))
    else $error("read and write mode together");
  a_write_no_drive: assert property (o_write_mode |-> !o_data_oe)
    else $error("data lines driven in write mode");
  a_read_tracks: assert property (o_read_mode && $past(o_read_mode) |-> o_data_oe && o_data == $past(i_ctl_rd_byte))
    else $error("read data not following core byte");
  a_soft_reset_clears: assert property (o_soft_reset |-> s_one_shot)
    else $error("software reset did not clear state");
  a_select_release: assert property (o_select && i_ctl_ready |=> !o_select)
    else $error("select not cleared by ready");
  a_led_fail_off: assert property (i_diag_fail && i_loopback_jumper |-> ##[1:3] (!o_power_led) [*8])
    else $error("light not off after failure");
  a_led_period: assert property (armed && $rose(o_power_led) && o_diag_run |-> led_cnt == LED_HALF)
    else $error("light flash period wrong");
endmodule

bind hbc_host_port hbc_host_port_assertions #(.LED_HALF(LED_HALF)) u_hbc_host_port_assertions (
  .i_clk(i_clk), .i_reset(i_reset), .i_loopback_jumper(i_loopback_jumper),
  .i_ctl_rd_byte(i_ctl_rd_byte), .i_ctl_busy(i_ctl_busy), .i_ctl_ready(i_ctl_ready),
  .i_ctl_irq(i_ctl_irq), .i_diag_fail(i_diag_fail), .o_data(o_data), .o_data_oe(o_data_oe),
  .o_read_mode(o_read_mode), .o_write_mode(o_write_mode), .o_select(o_select),
  .o_int_mask(o_int_mask), .o_irq(o_irq), .o_soft_reset(o_soft_reset),
  .o_diag_run(o_diag_run), .o_power_led(o_power_led));

// ==== test/hbc_host_port_tb.sv ====
/*
  Self-checking bench for the host command port.
  Host model drives commands; bench plays the controller core.
*/
`timescale 1ns/1ps
module hbc_host_port_tb import hbc_pkg::*;;
  logic i_clk = 1'b0, i_reset = 1'b1, i_loopback_jumper = 1'b0, i_parity_off_jumper = 1'b0;
  logic [3:0] i_addr_jumper = FACTORY_ADDR;
  logic [7:0] i_data = 8'h00, i_ctl_rd_byte = 8'h00, o_data, o_wr_byte, cmd_addr, seen_or = 8'h00;
  logic i_ctl_dir = 0, i_ctl_busy = 0, i_ctl_cmd_data = 0, i_ctl_message = 0, i_ctl_request = 0;
  logic i_ctl_ready = 0, i_ctl_irq = 0, i_diag_pass = 0, i_diag_fail = 0, cmd_par, s1, s2;
  logic o_data_oe, o_read_mode, o_write_mode, o_select, o_int_mask, o_irq, o_soft_reset, o_diag_run, o_power_led;
  logic collect = 1'b1;
  int error_cnt = 0, samples_checked = 0, n;
  always #10 i_clk = ~i_clk;
  // Collects every driven byte; one process owns seen_or
  always @(posedge i_clk) begin
    if (!collect) begin
      seen_or <= 8'h00;
    end else if (o_data_oe === 1'b1) begin
      seen_or <= seen_or | o_data;
    end
  end
  hbc_host_model u_hbc_host_model (.i_clk(i_clk), .o_cmd_addr(cmd_addr), .o_cmd_parity(cmd_par),
    .o_strobe1(s1), .o_strobe2(s2));
  hbc_host_port #(.LED_HALF(10)) u_hbc_host_port (.i_clk(i_clk), .i_reset(i_reset),
    .i_addr_jumper(i_addr_jumper), .i_loopback_jumper(i_loopback_jumper),
    .i_parity_off_jumper(i_parity_off_jumper), .i_cmd_addr(cmd_addr), .i_cmd_parity(cmd_par),
    .i_strobe1(s1), .i_strobe2(s2), .i_data(i_data), .i_ctl_rd_byte(i_ctl_rd_byte),
    .i_ctl_dir(i_ctl_dir), .i_ctl_busy(i_ctl_busy), .i_ctl_cmd_data(i_ctl_cmd_data),
    .i_ctl_message(i_ctl_message), .i_ctl_request(i_ctl_request), .i_ctl_ready(i_ctl_ready),
    .i_ctl_irq(i_ctl_irq), .i_diag_pass(i_diag_pass), .i_diag_fail(i_diag_fail), .o_data(o_data),
    .o_data_oe(o_data_oe), .o_wr_byte(o_wr_byte), .o_read_mode(o_read_mode),
    .o_write_mode(o_write_mode), .o_select(o_select), .o_int_mask(o_int_mask), .o_irq(o_irq),
    .o_soft_reset(o_soft_reset), .o_diag_run(o_diag_run), .o_power_led(o_power_led));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmd(input logic [3:0] code);
    u_hbc_host_model.send(code, FACTORY_ADDR, 1'b0, 1'b0);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  // Status read from idle so only status bytes collect
  task automatic status_flags(input logic [7:0] exp);
    cmd(4'h8);
    collect <= 1'b0;
    cyc(1);
    collect <= 1'b1;
    cmd(CMD_STATUS_READ);
    check(seen_or & 8'h06, exp);
  endtask
  initial begin
    cyc(20000);
    error_cnt++;
    end_sim();
  end
  initial begin
    cyc(12);
    i_reset <= 1'b0;
    cyc(6);
    check(8'(o_int_mask), 8'h01);
    check(8'(o_select), 8'h00);
    i_ctl_dir <= 1'b1;
    i_ctl_cmd_data <= 1'b1;
    i_ctl_message <= 1'b1;
    cmd(CMD_STATUS_READ);
    check(o_data, 8'h01);
    i_diag_pass <= 1'b1;
    cyc(1);
    i_diag_pass <= 1'b0;
    cmd(CMD_STATUS_READ);
    check(o_data, 8'h00);
    cmd(CMD_IDENT_READ);
    check(o_data, IDENT_BYTE);
    check(8'(o_data_oe), 8'h01);
    i_addr_jumper <= 4'hD;
    cyc(8);
    cmd(CMD_ENABLE_INT);
    check(8'(o_int_mask), 8'h01);
    u_hbc_host_model.send(CMD_ENABLE_INT, 4'hD, 1'b0, 1'b0);
    check(8'(o_int_mask), 8'h00);
    u_hbc_host_model.send(CMD_DISABLE_INT, 4'hD, 1'b0, 1'b0);
    i_addr_jumper <= FACTORY_ADDR;
    cyc(8);
    u_hbc_host_model.send(CMD_ENABLE_INT, FACTORY_ADDR, 1'b0, 1'b1);
    check(8'(o_int_mask), 8'h01);
    cmd(CMD_ENABLE_INT);
    check(8'(o_int_mask), 8'h00);
    i_ctl_irq <= 1'b1;
    cyc(3);
    check(8'(o_irq), 8'h01);
    i_ctl_busy <= 1'b1;
    cyc(3);
    check(8'(o_irq), 8'h00);
    cmd(CMD_SELECT);
    check(8'(o_select), 8'h00);
    i_ctl_busy <= 1'b0;
    cmd(CMD_DISABLE_INT);
    check(8'({o_int_mask, o_irq}), 8'h02);
    cmd(CMD_SELECT);
    check(8'(o_select), 8'h01);
    i_ctl_ready <= 1'b1;
    cyc(1);
    i_ctl_ready <= 1'b0;
    cyc(3);
    check(8'(o_select), 8'h00);
    i_ctl_request <= 1'b1;
    i_ctl_busy <= 1'b1;
    cmd(CMD_STATUS_READ);
    check(o_data, 8'hF8);
    i_ctl_busy <= 1'b0;
    i_ctl_rd_byte <= 8'hC3;
    cmd(CMD_READ_DATA);
    check(o_data, 8'hC3);
    i_ctl_rd_byte <= 8'h3C;
    cyc(3);
    check({o_data_oe, o_read_mode, o_data[5:0]}, 8'hFC);
    i_data <= 8'h96;
    cmd(CMD_WRITE_DATA);
    check(o_wr_byte, 8'h96);
    check(8'({o_write_mode, o_read_mode, o_data_oe}), 8'h04);
    i_ctl_request <= 1'b0;
    cmd(CMD_READ_DATA);
    check(8'(o_irq), 8'h01);
    status_flags(8'h04);
    cyc(3);
    check(8'(o_irq), 8'h00);
    u_hbc_host_model.send(CMD_ENABLE_INT, FACTORY_ADDR, 1'b1, 1'b0);
    check(8'({o_int_mask, o_irq}), 8'h03);
    status_flags(8'h02);
    // Parity jumper fitted: a bad-parity command is taken
    i_parity_off_jumper <= 1'b1;
    cyc(8);
    u_hbc_host_model.send(CMD_ENABLE_INT, FACTORY_ADDR, 1'b1, 1'b0);
    check(8'(o_int_mask), 8'h00);
    i_parity_off_jumper <= 1'b0;
    cyc(8);
    cmd(CMD_ENABLE_INT);
    cmd(CMD_SELECT);
    // Core interrupt dropped so the reset's irq clear is not an unmasked-irq miss
    i_ctl_irq <= 1'b0;
    cmd(CMD_SW_RESET);
    check(8'({o_int_mask, o_select, o_read_mode, o_write_mode}), 8'h08);
    cmd(CMD_STATUS_READ);
    check(o_data, 8'h00);
    i_loopback_jumper <= 1'b1;
    cyc(10);
    n = 0;
    repeat (100) begin
      cyc(1);
      n += (o_power_led === 1'b0) ? 1 : 0;
    end
    check(8'(n > 30 && n < 70), 8'h01);
    check(8'(o_diag_run), 8'h01);
    i_diag_fail <= 1'b1;
    cyc(1);
    i_diag_fail <= 1'b0;
    cyc(6);
    n = 0;
    repeat (40) begin
      cyc(1);
      n += (o_power_led === 1'b0) ? 1 : 0;
    end
    check(8'(n), 8'h28);
    cmd(CMD_STATUS_READ);
    check(o_data, 8'h01);
    end_sim();
  end
endmodule
